// ===== design/fpm_consts.svh
`ifndef FPM_CONSTS_SVH
`define FPM_CONSTS_SVH
// ----------------------------------------------------------------------------
// command codes and mask layout
// ----------------------------------------------------------------------------
`define FPM_CMD_CODE      8'hD2
`define FPM_MASK_RESET    16'h6993
`define FPM_MASK_WRITABLE 16'hE9FF
`define FPM_BIT_NODECAY   15
`define FPM_BIT_SHORTCYC  14
`define FPM_BIT_TONMAX    13
`define FPM_BIT_INTOT     11
`define FPM_BIT_UT        8
`define FPM_BIT_OT        7
`define FPM_BIT_VINOV     4
`define FPM_BIT_IOC       2
`define FPM_BIT_VUV       1
`define FPM_BIT_VOV       0
// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define FPM_CLK_HZ        10000000
`define FPM_SHORT_HOLD_MS 120
`define FPM_SHORT_HOLD_CYC ((`FPM_CLK_HZ / 1000) * `FPM_SHORT_HOLD_MS)
`endif

// ===== design/fpm_pkg.sv
`default_nettype none
// ----------------------------------------------------------------------------
// shared types
// ----------------------------------------------------------------------------
package fpm_pkg;
  typedef logic [15:0] fpm_mask_t;
  typedef enum logic [1:0] {
    FPM_IDLE   = 2'b00,
    FPM_ASSERT = 2'b01,
    FPM_HOLD   = 2'b11
  } fpm_short_state_t;
endpackage
`default_nettype wire

// ===== design/fpm_short_cycle.sv
`include "fpm_consts.svh"
`default_nettype none
// ----------------------------------------------------------------------------
// short command cycle tracker, one per channel
// ----------------------------------------------------------------------------
module fpm_short_cycle #(
  parameter int unsigned HOLD_CYC = `FPM_SHORT_HOLD_CYC
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic cmdOn,
  input  wire logic seqOffDone,
  output logic      active
);
  fpm_pkg::fpm_short_state_t state;
  fpm_pkg::fpm_short_state_t next_state;
  logic [23:0]               cnt;
  logic [23:0]               next_cnt;
  logic                      cmdOnD;
  logic                      next_cmdOnD;
  logic                      rise;

  // next state: on edge while not yet sequenced off, hold until done
  always_comb begin
    rise        = cmdOn & ~cmdOnD;
    next_cmdOnD = cmdOn;
    next_state  = state;
    next_cnt    = cnt;
    case (state)
      fpm_pkg::FPM_IDLE: begin
        if (rise && !seqOffDone) begin
          next_state = fpm_pkg::FPM_ASSERT;
        end
      end
      fpm_pkg::FPM_ASSERT: begin
        if (seqOffDone) begin
          next_state = fpm_pkg::FPM_HOLD;
          next_cnt   = 24'h000000;
        end
      end
      fpm_pkg::FPM_HOLD: begin
        if (cnt >= 24'(HOLD_CYC - 1)) begin
          next_state = fpm_pkg::FPM_IDLE;
        end else begin
          next_cnt = cnt + 24'h000001;
        end
      end
      default: next_state = fpm_pkg::FPM_IDLE;
    endcase
    active = (state != fpm_pkg::FPM_IDLE);
  end

  // registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state  <= fpm_pkg::FPM_IDLE;
      cnt    <= 24'h000000;
      cmdOnD <= 1'b1; // no false rise when already on at reset
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      cmdOnD <= next_cmdOnD;
    end
  end
endmodule
`default_nettype wire

// ===== design/fpm_fault_pin_propagation_mask.sv
// How it works
// - pin goes low when any enabled fault source of its channel is active.
// - a fault propagates only when its fault response is also enabled.
// - the mask command carries exactly two bytes, one 16-bit word.
// - with config bit 0 clear, restart waits for output decay to 12.5%.
// - mask bit 15 pulls pin low while restart waits for decay.
// - mask bit 14 pulls pin low on off-then-on before sequence-off ends.
// - short-cycle assertion releases 120 ms after the off-sequence completes.
// - mask bit 13 routes turn-on timeout fault to the pin.
// - channel faults go only to that channel's own pin.
// - mask bit 11 routes internal die overtemperature fault to the pin.
// - mask bit 8 routes external undertemperature fault to the pin.
// - mask bit 7 routes external overtemperature fault to the pin.
// - some events are common to both pins; pins can share faults.
// - paged read-write word command 0xD2, default 0x6993.
// - mask bit 4 routes input overvoltage fault to the pin.
// - mask bit 2 routes output overcurrent fault to the pin.
// - mask bit 1 routes output undervoltage fault to the pin.
`include "fpm_consts.svh"
`default_nettype none
module fpm_fault_pin_propagation_mask #(
  parameter int unsigned HOLD_CYC = `FPM_SHORT_HOLD_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // command port from the management interface decoder
  input  wire logic        cmdWrite,
  input  wire logic        cmdRead,
  input  wire logic [7:0]  cmdCode,
  input  wire logic        cmdPage,
  input  wire logic [1:0]  cmdByteCount,
  input  wire logic [15:0] cmdWrData,
  output logic      [15:0] cmdRdData,
  output logic             cmdRdValid,
  output logic             cmdError,
  // fault sources, index = page, except vinOvFault and internal_die_overtemp_fault, common to both
  input  wire logic [1:0]  voutOvFault,
  input  wire logic [1:0]  voutUvFault,
  input  wire logic [1:0]  ioutOcFault,
  input  wire logic [1:0]  tonMaxFault,
  input  wire logic [1:0]  extOtFault,
  input  wire logic [1:0]  extUtFault,
  input  wire logic        vinOvFault,
  input  wire logic        internal_die_overtemp_fault,
  // fault-response enables and sequencing status, per channel except respVinOv and respIntOt
  input  wire logic [1:0]  respVoutOv,
  input  wire logic [1:0]  respVoutUv,
  input  wire logic [1:0]  respIoutOc,
  input  wire logic [1:0]  respTonMax,
  input  wire logic [1:0]  respExtOt,
  input  wire logic [1:0]  respExtUt,
  input  wire logic        respVinOv,
  input  wire logic        respIntOt,
  input  wire logic [1:0]  chanCfgBit0,
  input  wire logic [1:0]  cmdOn,
  input  wire logic [1:0]  seqOffDone,
  input  wire logic [1:0]  outputDecayed,
  // alarm pins, open drain, plus restart permission
  input  wire logic        first_channel_alarm_pin_in,
  input  wire logic        second_channel_alarm_pin_in,
  output logic             first_channel_alarm_pin_oe,
  output logic             second_channel_alarm_pin_oe,
  output logic             first_channel_alarm_pin_out,
  output logic             second_channel_alarm_pin_out,
  output logic      [1:0]  restartAllowed,
  output logic      [1:0]  sharedFault
);
  fpm_pkg::fpm_mask_t mask [2];
  fpm_pkg::fpm_mask_t next_mask [2];
  logic [15:0] next_cmdRdData;
  logic        next_cmdRdValid;
  logic        next_cmdError;
  logic [1:0]  next_pinOe;
  logic [1:0]  next_restartAllowed;
  logic [1:0]  pinSync1;
  logic [1:0]  pinSync2;
  logic [1:0]  next_sharedFault;
  logic [1:0]  shortActive;
  logic [1:0]  offSeen;
  logic [1:0]  next_offSeen;
  logic        hit;

  // --------------------------------------------------------------------------
  // command register access
  // --------------------------------------------------------------------------
  always_comb begin
    next_mask       = mask;
    next_cmdRdData  = 16'h0000;
    next_cmdRdValid = 1'b0;
    next_cmdError   = 1'b0;
    hit = (cmdCode == `FPM_CMD_CODE);
    if (hit && (cmdWrite || cmdRead)) begin
      if (cmdByteCount != 2'h2) begin
        next_cmdError = 1'b1;
      end else if (cmdWrite) begin
        next_mask[cmdPage] = cmdWrData & `FPM_MASK_WRITABLE;
      end else begin
        next_cmdRdData  = mask[cmdPage];
        next_cmdRdValid = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // per-channel pin decision
  // --------------------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      fpm_short_cycle #(
        .HOLD_CYC (HOLD_CYC)
      ) u_short (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .cmdOn      (cmdOn[ch]),
        .seqOffDone (seqOffDone[ch]),
        .active     (shortActive[ch])
      );

      logic waitDecay;
      logic chanOffSeen;
      logic chanRestart;
      logic chanPinOe;
      assign waitDecay = ~chanCfgBit0[ch] & offSeen[ch] & cmdOn[ch]
                         & ~outputDecayed[ch];

      // each bit has one driver, so the channels never share a process
      assign next_offSeen[ch]        = chanOffSeen;
      assign next_restartAllowed[ch] = chanRestart;
      assign next_pinOe[ch]          = chanPinOe;

      always_comb begin
        chanOffSeen = offSeen[ch];
        if (!cmdOn[ch]) begin
          chanOffSeen = 1'b1;
        end else if (outputDecayed[ch]) begin
          // decayed while on: nothing left to wait for
          chanOffSeen = 1'b0;
        end
        chanRestart = ~waitDecay;
        // any enabled source, faults gated by response, own page
        chanPinOe =
          (mask[ch][`FPM_BIT_VOV]   & voutOvFault[ch] & respVoutOv[ch])
          | (mask[ch][`FPM_BIT_VUV] & voutUvFault[ch] & respVoutUv[ch])
          | (mask[ch][`FPM_BIT_IOC] & ioutOcFault[ch] & respIoutOc[ch])
          | (mask[ch][`FPM_BIT_VINOV] & vinOvFault & respVinOv)
          | (mask[ch][`FPM_BIT_OT]  & extOtFault[ch] & respExtOt[ch])
          | (mask[ch][`FPM_BIT_UT]  & extUtFault[ch] & respExtUt[ch])
          | (mask[ch][`FPM_BIT_INTOT] & internal_die_overtemp_fault
             & respIntOt)
          | (mask[ch][`FPM_BIT_TONMAX] & tonMaxFault[ch] & respTonMax[ch])
          | (mask[ch][`FPM_BIT_SHORTCYC] & shortActive[ch])
          | (mask[ch][`FPM_BIT_NODECAY] & waitDecay);
      end
    end
  endgenerate

  // pin level seen by its own channel, synchronised
  always_comb begin
    next_sharedFault = ~pinSync2;
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mask[0]        <= `FPM_MASK_RESET;
      mask[1]        <= `FPM_MASK_RESET;
      cmdRdData      <= 16'h0000;
      cmdRdValid     <= 1'b0;
      cmdError       <= 1'b0;
      restartAllowed <= 2'b11;
      offSeen        <= 2'b00;
      pinSync1       <= 2'b11;
      pinSync2       <= 2'b11;
      sharedFault    <= 2'b00;
    end else begin
      mask           <= next_mask;
      cmdRdData      <= next_cmdRdData;
      cmdRdValid     <= next_cmdRdValid;
      cmdError       <= next_cmdError;
      restartAllowed <= next_restartAllowed;
      offSeen        <= next_offSeen;
      pinSync1       <= {second_channel_alarm_pin_in,
                         first_channel_alarm_pin_in};
      pinSync2       <= pinSync1;
      sharedFault    <= next_sharedFault;
    end
  end

  // open drain: out constant low, enable from flop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      first_channel_alarm_pin_oe   <= 1'b0;
      second_channel_alarm_pin_oe  <= 1'b0;
      first_channel_alarm_pin_out  <= 1'b0;
      second_channel_alarm_pin_out <= 1'b0;
    end else begin
      first_channel_alarm_pin_oe   <= next_pinOe[0];
      second_channel_alarm_pin_oe  <= next_pinOe[1];
      first_channel_alarm_pin_out  <= 1'b0;
      second_channel_alarm_pin_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== dv/fpm_pin_model.sv
`default_nettype none
// --------
// open-drain pins with pull-up and a second party
// --------
module fpm_pin_model (
  input  wire logic       oe0,
  input  wire logic       oe1,
  input  wire logic       out0,
  input  wire logic       out1,
  input  wire logic [1:0] pullLow,
  output logic            pin0,
  output logic            pin1
);
  timeunit 1ns;
  timeprecision 1ns;
  assign pin0 = (oe0 ? out0 : 1'b1) & !pullLow[0];
  assign pin1 = (oe1 ? out1 : 1'b1) & !pullLow[1];
endmodule
`default_nettype wire

// ===== dv/fpm_checker.sv
`default_nettype none
module fpm_checker #(
  parameter int unsigned HOLD_CYC = 1200000
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        cmdWrite,
  input  wire logic        cmdRead,
  input  wire logic [7:0]  cmdCode,
  input  wire logic        cmdPage,
  input  wire logic [1:0]  cmdByteCount,
  input  wire logic [15:0] cmdWrData,
  input  wire logic [15:0] cmdRdData,
  input  wire logic        cmdRdValid,
  input  wire logic        cmdError,
  input  wire logic [1:0]  voutUvFault,
  input  wire logic [1:0]  respVoutUv,
  input  wire logic [1:0]  cmdOn,
  input  wire logic [1:0]  seqOffDone,
  input  wire logic [1:0]  chanCfgBit0,
  input  wire logic        first_channel_alarm_pin_oe,
  input  wire logic [1:0]  restartAllowed
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mask0;
  logic [15:0] next_mask0;
  logic        hit0;
  // --------
  // page 0 mask shadow
  // --------
  assign hit0 = cmdCode == 8'hD2 && !cmdPage && cmdByteCount == 2'h2;
  always_comb begin
    next_mask0 = mask0;
    if (cmdWrite && hit0) next_mask0 = cmdWrData & 16'hE9FF;
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) mask0 <= 16'h6993;
    else mask0 <= next_mask0;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_off0; !cmdOn[0] && !seqOffDone[0]; endsequence
  sequence s_on0; cmdOn[0] && !seqOffDone[0] && mask0[14]; endsequence
  AST_RD_WORD: assert property (
    cmdRead && hit0 |=> cmdRdValid && cmdRdData == $past(mask0))
    else $error("read word mismatch");
  AST_BAD_COUNT: assert property (
    (cmdRead || cmdWrite) && cmdCode == 8'hD2 && cmdByteCount != 2'h2
    |=> cmdError && !cmdRdValid) else $error("bad count not refused");
  AST_OTHER_CODE: assert property (
    cmdCode != 8'hD2 |=> !cmdError && !cmdRdValid) else $error("stray answer");
  AST_RD_IDLE: assert property (
    !cmdRdValid |-> cmdRdData == 16'h0000) else $error("stale read data");
  AST_UV_PIN: assert property (
    voutUvFault[0] && respVoutUv[0] && mask0[1] |=> first_channel_alarm_pin_oe)
    else $error("enabled fault not on pin");
  AST_SHORT: assert property (
    s_off0 ##1 s_on0 |-> ##[1:2] first_channel_alarm_pin_oe)
    else $error("short cycle not flagged");
  AST_SHORT_HOLD: assert property (
    first_channel_alarm_pin_oe && mask0[14] && !mask0[15]
    && $rose(seqOffDone[0]) |=> first_channel_alarm_pin_oe [*8])
    else $error("short hold too brief");
  AST_CFG_RUN: assert property (
    chanCfgBit0[0] ##1 chanCfgBit0[0] |-> restartAllowed[0])
    else $error("restart held with config bit set");
endmodule
bind fpm_fault_pin_propagation_mask fpm_checker #(.HOLD_CYC(HOLD_CYC)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
  .cmdCode(cmdCode), .cmdPage(cmdPage), .cmdByteCount(cmdByteCount),
  .cmdWrData(cmdWrData), .cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid),
  .cmdError(cmdError), .voutUvFault(voutUvFault), .respVoutUv(respVoutUv),
  .cmdOn(cmdOn), .seqOffDone(seqOffDone), .chanCfgBit0(chanCfgBit0),
  .first_channel_alarm_pin_oe(first_channel_alarm_pin_oe),
  .restartAllowed(restartAllowed));
`default_nettype wire

// ===== dv/test_fault_pin_propagation_mask.sv
`default_nettype none
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module test_fault_pin_propagation_mask;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst_n = 0, cmdWrite = 0, cmdRead = 0, cmdPage = 0;
  logic vinOv = 0, intOt = 0, respVinOv = 0, respIntOt = 0, cmdError;
  logic [7:0] cmdCode = 8'h00;
  logic [1:0] cmdByteCount = 2'h0, cfg = 2'h0, cmdOn = 2'h3, pull = 2'h0;
  logic [1:0] seqOffDone = 2'h0, decayed = 2'h3, restartAllowed, sharedFault;
  logic [1:0] flt [6] = '{default: 2'h0};
  logic [1:0] rsp [6] = '{default: 2'h0};
  logic [15:0] cmdWrData = 16'h0000, rdData;
  logic rdValid, oe0, oe1, out0, out1, pin0, pin1;
  int miscompares = 0, nChecks = 0;
  int bitOf [8] = '{0, 1, 2, 13, 7, 8, 4, 11};
  // --------
  // clock, device and pins
  // --------
  always #50 mclk = !mclk;
  fpm_fault_pin_propagation_mask #(.HOLD_CYC(20)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
    .cmdCode(cmdCode), .cmdPage(cmdPage), .cmdByteCount(cmdByteCount),
    .cmdWrData(cmdWrData), .cmdRdData(rdData), .cmdRdValid(rdValid),
    .cmdError(cmdError), .voutOvFault(flt[0]), .voutUvFault(flt[1]),
    .ioutOcFault(flt[2]), .tonMaxFault(flt[3]), .extOtFault(flt[4]),
    .extUtFault(flt[5]), .vinOvFault(vinOv),
    .internal_die_overtemp_fault(intOt), .respVoutOv(rsp[0]),
    .respVoutUv(rsp[1]), .respIoutOc(rsp[2]), .respTonMax(rsp[3]),
    .respExtOt(rsp[4]), .respExtUt(rsp[5]), .respVinOv(respVinOv),
    .respIntOt(respIntOt), .chanCfgBit0(cfg), .cmdOn(cmdOn),
    .seqOffDone(seqOffDone), .outputDecayed(decayed),
    .first_channel_alarm_pin_in(pin0), .second_channel_alarm_pin_in(pin1),
    .first_channel_alarm_pin_oe(oe0), .second_channel_alarm_pin_oe(oe1),
    .first_channel_alarm_pin_out(out0), .second_channel_alarm_pin_out(out1),
    .restartAllowed(restartAllowed), .sharedFault(sharedFault));
  fpm_pin_model u_pins (.oe0(oe0), .oe1(oe1), .out0(out0), .out1(out1),
    .pullLow(pull), .pin0(pin0), .pin1(pin1));
  // one command pulse, sampled after the answer edge
  task acc(logic w, logic [7:0] c, logic p, logic [1:0] n, logic [15:0] d);
    @(posedge mclk);
    {cmdWrite, cmdRead, cmdCode} <= {w, !w, c};
    {cmdPage, cmdByteCount, cmdWrData} <= {p, n, d};
    @(posedge mclk);
    {cmdWrite, cmdRead} <= 2'b00;
    #1;
  endtask
  // host clears reserved bits 12, 10 and 9 before writing
  task wr(logic p, logic [15:0] d);
    acc(1'b1, 8'hD2, p, 2'h2, d & 16'hE9FF);
  endtask
  task rd(logic p, logic [15:0] e);
    acc(1'b0, 8'hD2, p, 2'h2, 16'h0000);
    `CHK({rdValid, rdData}, {1'b1, e})
  endtask
  task w(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // drive one fault source and its response enable
  task src(int k, logic f, logic r);
    @(posedge mclk);
    if (k < 6) {flt[k], rsp[k]} <= {1'b0, f, r, r};
    else if (k == 6) {vinOv, respVinOv} <= {f, r};
    else {intOt, respIntOt} <= {f, r};
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog, run needs about 200 cycles
  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    finish_test;
  end
  // --------
  // tests
  // --------
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rd(1'b0, 16'h6993);
    rd(1'b1, 16'h6993);
    wr(1'b0, 16'hFFFF);
    wr(1'b1, 16'h0000);
    rd(1'b0, 16'hE9FF);
    rd(1'b1, 16'h0000);
    acc(1'b1, 8'hD2, 1'b0, 2'h1, 16'h0000);
    `CHK(cmdError, 1'b1)
    acc(1'b0, 8'hD2, 1'b0, 2'h3, 16'h0000);
    `CHK({cmdError, rdValid}, 2'b10)
    acc(1'b1, 8'hD3, 1'b0, 2'h2, 16'h0000);
    `CHK(cmdError, 1'b0)
    rd(1'b0, 16'hE9FF);
    $display("test commands done");
    wr(1'b1, 16'h29FF);
    for (int k = 0; k < 8; k++) begin
      wr(1'b0, 16'h0001 << bitOf[k]);
      src(k, 1'b1, 1'b1);
      w(2);
      `CHK({oe1, oe0}, {k > 5, 1'b1})
      `CHK({out1, out0}, 2'b00)
      src(k, 1'b1, 1'b0);
      w(2);
      `CHK({oe1, oe0}, 2'b00)
      wr(1'b0, 16'h29FF ^ (16'h0001 << bitOf[k]));
      src(k, 1'b1, 1'b1);
      w(2);
      `CHK({oe1, oe0}, {k > 5, 1'b0})
      src(k, 1'b0, 1'b0);
    end
    $display("test sources done");
    wr(1'b0, 16'h4000);
    @(posedge mclk) cmdOn <= 2'b10;
    w(2);
    @(posedge mclk) cmdOn <= 2'b11;
    w(3);
    `CHK(oe0, 1'b1)
    @(posedge mclk) seqOffDone <= 2'b01;
    w(10);
    `CHK(oe0, 1'b1)
    w(15);
    `CHK(oe0, 1'b0)
    $display("test short cycle done");
    wr(1'b0, 16'h8000);
    @(posedge mclk) {decayed, cmdOn} <= 4'b1010;
    w(2);
    @(posedge mclk) cmdOn <= 2'b11;
    w(3);
    `CHK({restartAllowed, oe0}, 3'b101)
    @(posedge mclk) decayed <= 2'b11;
    w(3);
    `CHK({restartAllowed, oe0}, 3'b110)
    // config bit 0 set: no decay hold and no pin action
    @(posedge mclk) {cfg, decayed, cmdOn} <= 6'b011010;
    w(2);
    @(posedge mclk) cmdOn <= 2'b11;
    w(3);
    `CHK({restartAllowed, oe0}, 3'b110)
    $display("test decay done");
    @(posedge mclk) {decayed, pull} <= 4'b1110;
    w(5);
    `CHK(sharedFault, 2'b10)
    @(posedge mclk) pull <= 2'b00;
    w(5);
    `CHK(sharedFault, 2'b00)
    `CHK({out1, out0}, 2'b00)
    $display("test sharing done");
    finish_test;
  end
endmodule
`default_nettype wire
